// >>> hdl/cpsi_pkg.sv
/*
 * cpsi_pkg: constants and carrier types for the core program counter,
 * return stack and interrupt control block.
 * assumes one instruction-cycle clock shared by decoder and this block.
 */
package cpsi_pkg;
	// ***************************************************************
	// register file addresses (both banks where mirrored)
	// ***************************************************************
	localparam logic [7:0] ADDR_PC_LOW_B0 = 8'h02;
	localparam logic [7:0] ADDR_PC_LOW_B1 = 8'h82;
	localparam logic [7:0] ADDR_STATUS_B0 = 8'h03;
	localparam logic [7:0] ADDR_STATUS_B1 = 8'h83;
	localparam logic [7:0] ADDR_HOLD_B0 = 8'h0a;
	localparam logic [7:0] ADDR_HOLD_B1 = 8'h8a;
	localparam logic [7:0] ADDR_CORE_IRQ_B0 = 8'h0b;
	localparam logic [7:0] ADDR_CORE_IRQ_B1 = 8'h8b;
	localparam logic [7:0] ADDR_PFLAG1 = 8'h0c;
	localparam logic [7:0] ADDR_PFLAG2 = 8'h0d;
	localparam logic [7:0] ADDR_OPTION = 8'h81;
	localparam logic [7:0] ADDR_PEN1 = 8'h8c;
	localparam logic [7:0] ADDR_PEN2 = 8'h8d;
	localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8e;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int ST_CARRY = 0;
	localparam int ST_NIBBLE = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_SLEEP = 3;
	localparam int ST_WDOG = 4;
	localparam int IC_MASTER = 7;
	localparam int IC_PERIPH = 6;
	localparam int HOLD_PAGE = 3;
	localparam int RC_POWER_ON = 1;

	// ***************************************************************
	// widths, vectors, reset values
	// ***************************************************************
	localparam int PC_W = 13;
	localparam int STACK_DEPTH = 8;
	localparam int STACK_AW = 3;
	localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
	localparam logic [PC_W-1:0] PC_WRAP_MASK = 13'h0fff;
	localparam logic [7:0] OPTION_RESET = 8'hff;
	localparam logic [7:0] STATUS_RESET = 8'h18;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [1:0] RC_RESET = 2'h0;
	// pending irq is sampled two cycles, then dispatched: 3..4 cycles
	localparam logic [1:0] IRQ_SYNC_CYCLES = 2'h2;

	typedef enum logic [2:0] {
		CPSI_OP_NONE, CPSI_OP_GOTO, CPSI_OP_CALL, CPSI_OP_RETURN,
		CPSI_OP_RETURN_WITH_LITERAL_OP, CPSI_OP_IRQ_RETURN_OP
	} cpsi_flow_t;

	// decoder -> block
	typedef struct packed {
		cpsi_flow_t flow;
		logic [10:0] target;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [7:0] wr_data;
		logic alu_flags_en;
		logic [2:0] alu_flags;
		logic [7:0] rd_addr;
	} cpsi_cmd_t;

	// peripheral and reset-cause events, one-cycle pulses
	typedef struct packed {
		logic timer_overflow;
		logic ext_edge;
		logic port_change;
		logic [7:0] periph1;
		logic periph2;
		logic watchdog_expired;
		logic sleep_entered;
		logic wake_clear;
	} cpsi_evt_t;
endpackage : cpsi_pkg

// >>> hdl/cpsi_stack.sv
/*
 * cpsi_stack: eight-entry circular return stack of program addresses.
 * assumes push and pop are never asked in the same cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module cpsi_stack
	import cpsi_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic push,
	input wire logic pop,
	input wire logic [PC_W-1:0] push_data,
	output logic [PC_W-1:0] top
);
	logic [PC_W-1:0] entry [STACK_DEPTH];
	logic [STACK_AW-1:0] ptr;
	wire [STACK_AW-1:0] pop_idx = ptr - 3'h1;

	// no full/empty tracking: the pointer simply wraps
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr <= '0;
		end else if (push) begin
			ptr <= ptr + 3'h1;
		end else if (pop) begin
			ptr <= pop_idx;
		end
	end

	genvar i;
	generate
		for (i = 0; i < STACK_DEPTH; i++) begin : g_entry
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					entry[i] <= '0;
				end else if (push && ptr == STACK_AW'(i)) begin
					entry[i] <= push_data;
				end
			end
		end
	endgenerate

	assign top = entry[pop_idx];

	ninth_wrap_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		push && !pop |=> entry[$past(ptr)] == $past(push_data))
		else $error("stack push did not land at pointer");
endmodule : cpsi_stack
`default_nettype wire

// >>> hdl/cpsi_irq.sv
/*
 * cpsi_irq: request qualification and dispatch delay.
 * assumes flags and enables arrive registered on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module cpsi_irq
	import cpsi_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] core_ctl,
	input wire logic [7:0] pflag1,
	input wire logic [7:0] pen1,
	input wire logic pflag2,
	input wire logic pen2,
	output logic take
);
	wire core_hit = |(core_ctl[5:3] & core_ctl[2:0]);
	wire per_hit = core_ctl[IC_PERIPH] & (|(pflag1 & pen1) | (pflag2 & pen2));
	wire request = core_ctl[IC_MASTER] & (core_hit | per_hit);
	logic [1:0] wait_cnt;

	// fixed wait so one- and two-cycle instructions see equal latency
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_cnt <= '0;
		end else if (!request || take) begin
			wait_cnt <= '0;
		end else if (wait_cnt != IRQ_SYNC_CYCLES) begin
			wait_cnt <= wait_cnt + 2'h1;
		end
	end

	assign take = request && wait_cnt == IRQ_SYNC_CYCLES;

	sequence s_req3;
		request [*3];
	endsequence
	irq_latency_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		!request ##1 s_req3 |-> take)
		else $error("interrupt not taken within latency");
	gated_req_a: assert property (
		@(posedge clk) disable iff (!rst_b)
		take |-> core_ctl[IC_MASTER])
		else $error("interrupt taken with master enable clear");
endmodule : cpsi_irq
`default_nettype wire

// >>> hdl/cpsi_core_ctrl.sv
/*
 * cpsi_core_ctrl: program counter, paging, return stack, interrupt
 * registers and dispatch, status write rules, reset-cause flags.
 * assumes the decoder drives one command per instruction cycle on
 * SYS_CLK and that event inputs are already synchronous pulses.
 */
// Function
// - alu flags override status writes to them
// - watchdog and sleep bits ignore writes
// - subtraction carries are inverted borrow outputs
// - status bits seven, six have no effect
// - option register fully readable and writable
// - core flags in control; peripheral flags separate
// - master enable gates every interrupt
// - RST_B clears master enable; pin and watchdog resets do not
// - accept: clear enable, push, vector to four
// - external events vector in three-four cycles
// - flags set regardless of enables
// - irq return pops and sets master enable
// - peripheral enable registers mirror flag bits
// - reset-cause register tells reset kinds apart
// - thirteen-bit counter, low byte readable both banks
// - new counter loads upper bits from holding
// - eight by thirteen stack, hidden pointer
// - push on call/irq, pop on returns
// - stack wraps, no overflow indication
// - page bit from holding bit three
// - holding bit four ignored for addressing
// - addresses above 4K wrap into range
`timescale 1ns/1ns
`default_nettype none
module cpsi_core_ctrl
	import cpsi_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RST_B,
	input wire logic EXT_RESET_PIN_B,
	input wire cpsi_cmd_t CMD,
	input wire cpsi_evt_t EVT,
	output logic [PC_W-1:0] PROG_ADDR,
	output logic [7:0] RD_DATA,
	output logic IRQ_TAKEN,
	output logic [7:0] OPTION_CFG
);
	// ***************************************************************
	// state
	// ***************************************************************
	logic [PC_W-1:0] pc;
	logic [7:0] pc_high_holding;
	logic [7:0] status;
	logic [7:0] core_irq_control;
	logic [7:0] periph_flags_one;
	logic periph_flags_two;
	logic [7:0] periph_enables_one;
	logic periph_enables_two;
	logic [7:0] prescale_config;
	logic [1:0] reset_cause;
	logic pin_meta, pin_sync;
	logic take;
	logic [PC_W-1:0] stack_top;

	// ***************************************************************
	// decode
	// ***************************************************************
	wire wr = CMD.wr_en;
	wire [7:0] wa = CMD.wr_addr;
	wire wr_pcl = wr && (wa == ADDR_PC_LOW_B0 || wa == ADDR_PC_LOW_B1);
	wire wr_st = wr && (wa == ADDR_STATUS_B0 || wa == ADDR_STATUS_B1);
	wire wr_hold = wr && (wa == ADDR_HOLD_B0 || wa == ADDR_HOLD_B1);
	wire wr_ic = wr && (wa == ADDR_CORE_IRQ_B0 || wa == ADDR_CORE_IRQ_B1);
	wire wr_pf1 = wr && wa == ADDR_PFLAG1;
	wire wr_pf2 = wr && wa == ADDR_PFLAG2;
	wire wr_pe1 = wr && wa == ADDR_PEN1;
	wire wr_pe2 = wr && wa == ADDR_PEN2;
	wire wr_opt = wr && wa == ADDR_OPTION;
	wire wr_rc = wr && wa == ADDR_RESET_CAUSE;
	wire is_call = CMD.flow == CPSI_OP_CALL;
	wire is_goto = CMD.flow == CPSI_OP_GOTO;
	wire is_ret = CMD.flow == CPSI_OP_RETURN
		|| CMD.flow == CPSI_OP_RETURN_WITH_LITERAL_OP || CMD.flow == CPSI_OP_IRQ_RETURN_OP;
	wire is_irq_return_op = CMD.flow == CPSI_OP_IRQ_RETURN_OP;
	// an accepted interrupt replaces the current flow change
	wire push = take || is_call;
	wire pop = !take && is_ret;
	wire [PC_W-1:0] pc_inc = pc + 13'h1;
	// bit four of holding never reaches the counter
	wire [PC_W-1:0] jump_pc = {1'b0, pc_high_holding[HOLD_PAGE], CMD.target};
	wire [PC_W-1:0] pcl_pc = {pc_high_holding[4:0], CMD.wr_data};
	logic [PC_W-1:0] next_pc;
	always_comb begin
		if (take) begin
			next_pc = IRQ_VECTOR;
		end else if (is_call || is_goto) begin
			next_pc = jump_pc;
		end else if (pop) begin
			next_pc = stack_top;
		end else if (wr_pcl) begin
			next_pc = pcl_pc;
		end else begin
			next_pc = pc_inc;
		end
	end
	// upper page simply aliases onto the implemented 4K
	wire [PC_W-1:0] fetch_addr = next_pc & PC_WRAP_MASK;

	// status: hardware-only bits are write-blocked, alu flag bits only while alu_flags_en is set
	wire [7:0] st_wmask = CMD.alu_flags_en ? 8'he0 : 8'he7;
	wire [7:0] st_written = wr_st
		? (status & ~st_wmask) | (CMD.wr_data & st_wmask) : status;
	logic [7:0] next_status;
	always_comb begin
		next_status = st_written;
		if (CMD.alu_flags_en) begin
			// decoder supplies carry/nibble as inverted borrow for subtract
			next_status[2:0] = CMD.alu_flags;
		end
		if (EVT.watchdog_expired) begin
			next_status[ST_WDOG] = 1'b0;
		end
		if (EVT.sleep_entered) begin
			next_status[ST_SLEEP] = 1'b0;
		end
		if (EVT.wake_clear) begin
			next_status[ST_WDOG] = 1'b1;
			next_status[ST_SLEEP] = 1'b1;
		end
	end

	// core control: hardware flag sets win over software clears
	wire [7:0] ic_base = wr_ic ? CMD.wr_data : core_irq_control;
	wire [2:0] ic_set = {EVT.timer_overflow, EVT.ext_edge, EVT.port_change};
	logic [7:0] next_ic;
	always_comb begin
		next_ic = {ic_base[7:3], ic_base[2:0] | ic_set};
		if (take) begin
			next_ic[IC_MASTER] = 1'b0;
		end else if (is_irq_return_op) begin
			next_ic[IC_MASTER] = 1'b1;
		end
	end
	wire [7:0] pf1_base = wr_pf1 ? CMD.wr_data : periph_flags_one;
	wire [7:0] next_pf1 = pf1_base | EVT.periph1;
	wire pf2_base = wr_pf2 ? CMD.wr_data[0] : periph_flags_two;
	wire next_pf2 = pf2_base | EVT.periph2;

	// ***************************************************************
	// registers
	// ***************************************************************
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pc <= RESET_VECTOR;
			PROG_ADDR <= RESET_VECTOR;
		end else begin
			pc <= fetch_addr;
			PROG_ADDR <= fetch_addr;
		end
	end

	// stack traffic leaves the holding register alone
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pc_high_holding <= BYTE_ZERO;
		end else if (wr_hold) begin
			pc_high_holding <= {3'h0, CMD.wr_data[4:0]};
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			status <= STATUS_RESET;
			core_irq_control <= BYTE_ZERO;
			periph_flags_one <= BYTE_ZERO;
			periph_flags_two <= 1'b0;
		end else begin
			status <= next_status;
			core_irq_control <= next_ic;
			periph_flags_one <= next_pf1;
			periph_flags_two <= next_pf2;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			periph_enables_one <= BYTE_ZERO;
			periph_enables_two <= 1'b0;
			prescale_config <= OPTION_RESET;
			OPTION_CFG <= OPTION_RESET;
		end else begin
			if (wr_pe1) periph_enables_one <= CMD.wr_data;
			if (wr_pe2) periph_enables_two <= CMD.wr_data[0];
			if (wr_opt) begin
				prescale_config <= CMD.wr_data;
				OPTION_CFG <= CMD.wr_data;
			end
		end
	end

	// reset pin seen through two flops before anyone reads it
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			pin_meta <= EXT_RESET_PIN_B;
			pin_sync <= pin_meta;
		end
	end

	// power-on flag: cleared by power-on reset, set by software;
	// bit 0 latches a pin reset, bit 1 a watchdog expiry
	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			reset_cause <= RC_RESET;
		end else if (wr_rc) begin
			reset_cause <= CMD.wr_data[1:0] | {EVT.watchdog_expired, !pin_sync};
		end else begin
			reset_cause <= reset_cause | {EVT.watchdog_expired, !pin_sync};
		end
	end

	// ***************************************************************
	// read mux; upper counter bits have no address
	// ***************************************************************
	wire [7:0] ra = CMD.rd_addr;
	// bits seven and six of status are kept but steer nothing
	wire [7:0] rd_mux =
		(ra == ADDR_PC_LOW_B0 || ra == ADDR_PC_LOW_B1) ? pc[7:0] :
		(ra == ADDR_STATUS_B0 || ra == ADDR_STATUS_B1) ? status :
		(ra == ADDR_HOLD_B0 || ra == ADDR_HOLD_B1) ? pc_high_holding :
		(ra == ADDR_CORE_IRQ_B0 || ra == ADDR_CORE_IRQ_B1) ? core_irq_control :
		(ra == ADDR_PFLAG1) ? periph_flags_one :
		(ra == ADDR_PFLAG2) ? {7'h0, periph_flags_two} :
		(ra == ADDR_PEN1) ? periph_enables_one :
		(ra == ADDR_PEN2) ? {7'h0, periph_enables_two} :
		(ra == ADDR_OPTION) ? prescale_config :
		(ra == ADDR_RESET_CAUSE) ? {6'h0, reset_cause} : BYTE_ZERO;

	always_ff @(posedge SYS_CLK or negedge RST_B) begin
		if (!RST_B) begin
			RD_DATA <= BYTE_ZERO;
			IRQ_TAKEN <= 1'b0;
		end else begin
			RD_DATA <= rd_mux;
			IRQ_TAKEN <= take;
		end
	end

	// ***************************************************************
	// submodules
	// ***************************************************************
	cpsi_stack u_stack (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.push(push),
		.pop(pop),
		.push_data(pc), // whole 13-bit counter
		.top(stack_top)
	);

	cpsi_irq u_irq (
		.clk(SYS_CLK),
		.rst_b(RST_B),
		.core_ctl(core_irq_control),
		.pflag1(periph_flags_one),
		.pen1(periph_enables_one),
		.pflag2(periph_flags_two),
		.pen2(periph_enables_two),
		.take(take)
	);

	// ***************************************************************
	// checks
	// ***************************************************************
	sequence s_accept;
		take;
	endsequence
	irq_dispatch_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		s_accept |=> pc == IRQ_VECTOR && !core_irq_control[IC_MASTER])
		else $error("irq accept did not vector or clear enable");
	irq_return_op_pop_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		is_irq_return_op && !take |=> core_irq_control[IC_MASTER]
			&& pc == ($past(stack_top) & PC_WRAP_MASK))
		else $error("irq return did not pop or re-enable");
	alu_flag_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		CMD.alu_flags_en |=> status[2:0] == $past(CMD.alu_flags))
		else $error("alu flags lost to status write");
	hw_bits_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		wr_st && !EVT.watchdog_expired && !EVT.sleep_entered
			&& !EVT.wake_clear |=> $stable(status[4:3]))
		else $error("hardware status bits changed by write");
	flag_set_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		EVT.ext_edge |=> core_irq_control[1])
		else $error("external flag not set by event");
	pflag_set_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		EVT.periph2 |=> periph_flags_two)
		else $error("second peripheral flag not set by event");
	page_load_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		is_goto && !take |=> pc[11] == $past(pc_high_holding[HOLD_PAGE])
			&& pc[12] == 1'b0)
		else $error("jump page bit not from holding register");
	pcl_write_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		wr_pcl && CMD.flow == CPSI_OP_NONE && !take
			|=> pc[11:8] == $past(pc_high_holding[3:0]))
		else $error("low byte write did not take holding bits");
	hold_keep_a: assert property (
		@(posedge SYS_CLK) disable iff (!RST_B)
		(push || pop) && !wr_hold |=> $stable(pc_high_holding))
		else $error("stack op altered holding register");
endmodule : cpsi_core_ctrl
`default_nettype wire

// >>> verif/cpsi_decoder_model.sv
/*
 * cpsi_decoder_model: stands in for the instruction decoder and the
 * peripheral event sources, one command or event set per cycle.
 * assumes the caller is just past a rising edge when a task starts.
 */
`timescale 1ns/1ns
`default_nettype none
module cpsi_decoder_model
	import cpsi_pkg::*;
#(
	parameter int GAP = 0
)
(
	input wire logic clk,
	input wire logic [7:0] rd_data,
	output var cpsi_cmd_t cmd,
	output var cpsi_evt_t evt
);
	initial begin
		cmd = '0;
		evt = '0;
	end

	// *************************************************************
	// one instruction cycle, then idle for GAP cycles (slow decoder)
	// *************************************************************
	task automatic tick();
		@(posedge clk);
		#1;
		if (GAP > 0) begin
			cmd = '0;
			evt = '0;
			repeat (GAP) @(posedge clk);
			#1;
		end
	endtask : tick

	// each call sets command and events once and, with GAP of 0, holds them to the
	// next call, so back-to-back calls never touch a signal twice
	task automatic step();
		cmd = '0;
		evt = '0;
		tick();
	endtask : step

	// af[3] asks the alu to own the low status bits this cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] af);
		cpsi_cmd_t c;
		c = '0;
		c.wr_en = 1'b1;
		c.wr_addr = a;
		c.wr_data = d;
		c.alu_flags_en = af[3];
		c.alu_flags = af[2:0];
		cmd = c;
		evt = '0;
		tick();
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		cpsi_cmd_t c;
		c = '0;
		c.rd_addr = a;
		cmd = c;
		evt = '0;
		tick();
		v = rd_data;
	endtask : rd

	task automatic flow(input cpsi_flow_t f, input logic [10:0] t);
		cpsi_cmd_t c;
		c = '0;
		c.flow = f;
		c.target = t;
		cmd = c;
		evt = '0;
		tick();
	endtask : flow

	task automatic pulse(input cpsi_evt_t e);
		cmd = '0;
		evt = e;
		tick();
	endtask : pulse
endmodule : cpsi_decoder_model
`default_nettype wire

// >>> verif/core_pc_stack_interrupt_ctrl_tb.sv
/*
 * core_pc_stack_interrupt_ctrl_tb: register, paging, stack and
 * interrupt tests of cpsi_core_ctrl driven through the decoder model.
 * assumes a 100 MHz SYS_CLK and the read latency of one cycle.
 */
`timescale 1ns/1ns
`default_nettype none
module core_pc_stack_interrupt_ctrl_tb;
	import cpsi_pkg::*;
	logic SYS_CLK = 1'b0;
	logic RST_B = 1'b0;
	logic EXT_RESET_PIN_B = 1'b1;
	cpsi_cmd_t cmd;
	cpsi_evt_t evt;
	logic [PC_W-1:0] prog_addr;
	logic [7:0] rd_data;
	logic irq_taken;
	logic [7:0] option_cfg;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	int n_taken = 0;
	int k;
	logic [7:0] v;
	logic [PC_W-1:0] p [0:8];
	cpsi_evt_t e;

	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end

	cpsi_decoder_model #(.GAP(0)) u (.clk(SYS_CLK), .rd_data(rd_data),
		.cmd(cmd), .evt(evt));

	cpsi_core_ctrl dut (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
		.EXT_RESET_PIN_B(EXT_RESET_PIN_B), .CMD(cmd), .EVT(evt),
		.PROG_ADDR(prog_addr), .RD_DATA(rd_data), .IRQ_TAKEN(irq_taken),
		.OPTION_CFG(option_cfg));

	// *************************************************************
	// checking and closing
	// *************************************************************
	task automatic chk(input string nm, input logic [12:0] seen,
		input logic [12:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [7:0] x);
		u.rd(a, v);
		chk(nm, {5'h00, v}, {5'h00, x});
	endtask : rchk

	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	// waits at most seven edges for the vector; returns edges seen
	task automatic wait_vec(output int n);
		n = 1;
		while (prog_addr !== IRQ_VECTOR && n < 8) begin
			u.step();
			n++;
		end
	endtask : wait_vec

	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (irq_taken === 1'b1) n_taken <= n_taken + 1;
		if (cyc == 3000) begin
			n_errors++;
			$display("BAD timeout expected finish seen hang");
			summarize();
		end
	end

	initial begin
		repeat (3) @(posedge SYS_CLK);
		#1;
		RST_B = 1'b1;
		chk("pc", prog_addr, RESET_VECTOR);
		chk("option pins", {5'h00, option_cfg}, {5'h00, OPTION_RESET});
		rchk("option", ADDR_OPTION, OPTION_RESET);
		rchk("status", ADDR_STATUS_B0, STATUS_RESET);
		rchk("control", ADDR_CORE_IRQ_B0, 8'h00);
		rchk("cause", ADDR_RESET_CAUSE, 8'h00);
		$display("test reset values done");

		u.wr(ADDR_OPTION, 8'h5a, 4'h0);
		chk("option pins", {5'h00, option_cfg}, 13'h005a);
		rchk("option", ADDR_OPTION, 8'h5a);
		u.wr(ADDR_PEN1, 8'ha5, 4'h0);
		rchk("enables1", ADDR_PEN1, 8'ha5);
		u.wr(ADDR_PEN2, 8'h01, 4'h0);
		rchk("enables2", ADDR_PEN2, 8'h01);
		u.wr(ADDR_PEN1, 8'h00, 4'h0);
		u.wr(ADDR_STATUS_B1, 8'h27, 4'hc);
		rchk("status", ADDR_STATUS_B0, 8'h3c);
		e = '0;
		e.watchdog_expired = 1'b1;
		u.pulse(e);
		rchk("status", ADDR_STATUS_B1, 8'h2c);
		rchk("cause", ADDR_RESET_CAUSE, 8'h02);
		$display("test registers done");

		u.wr(ADDR_HOLD_B1, 8'hff, 4'h0);
		rchk("holding", ADDR_HOLD_B0, 8'h1f);
		u.flow(CPSI_OP_GOTO, 11'h7ff);
		chk("pc", prog_addr, 13'h0fff);
		u.wr(ADDR_PC_LOW_B1, 8'h34, 4'h0);
		chk("pc", prog_addr, 13'h0f34);
		u.wr(ADDR_HOLD_B0, 8'h00, 4'h0);
		$display("test paging done");

		// nine calls: the ninth lands on the first slot again
		for (k = 0; k < 9; k++) begin
			u.flow(CPSI_OP_GOTO, 11'(k * 16 + 1));
			p[k] = prog_addr;
			u.flow(CPSI_OP_CALL, 11'h700);
			chk("pc", prog_addr, 13'h0700);
		end
		rchk("holding", ADDR_HOLD_B0, 8'h00);
		for (k = 8; k > 0; k--) begin
			u.flow((k % 2) ? CPSI_OP_RETURN_WITH_LITERAL_OP : CPSI_OP_RETURN, 11'h000);
			chk("pc", prog_addr, p[k]);
		end
		u.flow(CPSI_OP_RETURN, 11'h000);
		chk("pc", prog_addr, p[8]);
		$display("test stack done");

		e = '0;
		e.timer_overflow = 1'b1;
		e.periph1 = 8'h08;
		u.pulse(e);
		rchk("control", ADDR_CORE_IRQ_B0, 8'h04);
		rchk("flags1", ADDR_PFLAG1, 8'h08);
		chk("taken", 13'(n_taken), 13'h0);
		u.wr(ADDR_PFLAG1, 8'h00, 4'h0);
		u.wr(ADDR_CORE_IRQ_B0, 8'h90, 4'h0);
		e = '0;
		e.ext_edge = 1'b1;
		u.pulse(e);
		wait_vec(k);
		chk("latency", 13'(k >= 3 && k <= 4), 13'h1);
		rchk("control", ADDR_CORE_IRQ_B0, 8'h12);
		chk("taken", 13'(n_taken), 13'h1);
		u.wr(ADDR_CORE_IRQ_B1, 8'h10, 4'h0);
		u.flow(CPSI_OP_IRQ_RETURN_OP, 11'h000);
		rchk("control", ADDR_CORE_IRQ_B0, 8'h90);
		$display("test external interrupt done");

		u.wr(ADDR_PEN1, 8'h08, 4'h0);
		e = '0;
		e.periph1 = 8'h08;
		u.pulse(e);
		repeat (6) u.step();
		chk("taken", 13'(n_taken), 13'h1);
		u.wr(ADDR_CORE_IRQ_B0, 8'hd0, 4'h0);
		wait_vec(k);
		chk("pc", prog_addr, IRQ_VECTOR);
		u.step();
		chk("taken", 13'(n_taken), 13'h2);
		u.wr(ADDR_PFLAG1, 8'h00, 4'h0);
		$display("test peripheral interrupt done");

		e = '0;
		e.port_change = 1'b1;
		e.periph2 = 1'b1;
		e.sleep_entered = 1'b1;
		u.pulse(e);
		rchk("control", ADDR_CORE_IRQ_B1, 8'h51);
		rchk("flags2", ADDR_PFLAG2, 8'h01);
		rchk("status", ADDR_STATUS_B0, 8'h24);
		e = '0;
		e.wake_clear = 1'b1;
		u.pulse(e);
		rchk("status", ADDR_STATUS_B0, 8'h3c);
		u.wr(ADDR_CORE_IRQ_B0, 8'hc0, 4'h0);
		wait_vec(k);
		chk("pc", prog_addr, IRQ_VECTOR);
		u.step();
		chk("taken", 13'(n_taken), 13'h3);
		u.wr(ADDR_PFLAG2, 8'h00, 4'h0);
		rchk("flags2", ADDR_PFLAG2, 8'h00);
		$display("test second flag and sleep bits done");

		EXT_RESET_PIN_B = 1'b0;
		repeat (3) u.step();
		EXT_RESET_PIN_B = 1'b1;
		repeat (3) u.step();
		rchk("cause", ADDR_RESET_CAUSE, 8'h03);
		u.wr(ADDR_CORE_IRQ_B0, 8'h80, 4'h0);
		RST_B = 1'b0;
		u.step();
		RST_B = 1'b1;
		chk("pc", prog_addr, RESET_VECTOR);
		rchk("control", ADDR_CORE_IRQ_B0, 8'h00);
		$display("test reset cause done");
		summarize();
	end
endmodule : core_pc_stack_interrupt_ctrl_tb
`default_nettype wire
